// ### design/ext_bus_region_regs.vh
// Register offsets, field positions, codes and reset values of the external bus region block.
// Behaviour
// - One cycle after the address arrives, compare it; no enabled region hit gives error.
// - Several hits pass on the lowest numbered matching region.
// - Next cycle select and check the region parameters; invalid access gives error.
// - A valid access starts the external cycle one cycle after parameter selection.
// - Each region picks demultiplexed, multiplexed, burst flash or one of two DRAM types.
// - A disabled region always misses, whatever its base and mask.
// - The mask counts compared base bits downward from address bit 26.
// - Every region, all eight of them, has a write protect bit blocking writes.
// - Little endian default; big endian swap only on 16-bit regions.
// - Big endian flips low address bits: halfword xor 10, byte xor 11.
// - Accesses wider than the port split into ascending external beats.
// - The external bus stays owned until the whole split sequence ends.
// - On 32-bit regions local bus address bit 2 picks the 32-bit data half.
// - On 16-bit regions local bus address bits 2 and 1 pick the byte pair.
// - Big endian 16-bit: 64-bit gives 010,000,110,100; 32-bit gives 10,00.
// - On 16-bit regions peripheral bus address bit 1 picks the halfword.
// - The synchronous clock is the system clock divided by one, two or four.
// - Alignment drives address bits 24:1 for 16-bit and 25:2 for 32-bit ports.
// - Aligned 32-bit multiplexed address is byte address 31:2 with two zero top bits.
// - Alignment is off after reset; then the plain byte address goes out.
// - The indicator is low with the select during a modify read, else high.
`ifndef EXT_BUS_REGION_REGS_VH
`define EXT_BUS_REGION_REGS_VH

`define OFS_CON         7'h40
`define OFS_STATUS      7'h44
`define OFS_TABLE_BIT   6
`define OFS_BUSCON_BIT  2

`define ASEL_EN         0
`define ASEL_ALTERNATE_SEGMENT_ENABLE      1
`define ASEL_MASK_LO    4
`define ASEL_ALTERNATE_SEGMENT_LO  8
`define ASEL_BASE_LO    12

`define BC_ATYPE_LO     0
`define BC_PW_LO        4
`define BC_ENDIAN       6
`define BC_WP           7
`define BC_ALIGN        8

`define CON_DIV_LO      0
`define STAT_HOLD       0
`define STAT_REGION_LO  1
`define STAT_STATE_LO   4

`define ADDSEL_RST      32'h0000_0000
`define BUSCON_RST      32'h0000_0020
`define CON_RST         32'h0000_0000

`define AT_DEMUX        3'h0
`define AT_MUX          3'h1
`define AT_BFLASH       3'h2
`define AT_SDRAM0       3'h3
`define AT_SDRAM1       3'h4

`define PW_16           2'h1
`define PW_32           2'h2

`define SZ_8            2'h0
`define SZ_16           2'h1
`define SZ_32           2'h2
`define SZ_64           2'h3

`define DIV_1           2'h0
`define DIV_2           2'h1

`endif

// ### design/ext_bus_region.v
// External bus region matching, parameter selection and external access sequencing.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ext_bus_region_regs.vh"

module ext_bus_region (
    // Clock and reset.
    input  wire        clk_sys_i,
    input  wire        nrst_i,
    // Avalon-MM register slave.
    input  wire [6:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Internal request port.
    input  wire        req_valid_i,
    input  wire        req_src_i,
    input  wire [31:0] req_addr_i,
    input  wire [1:0]  req_size_i,
    input  wire        req_write_i,
    input  wire        req_rmw_i,
    input  wire [63:0] req_wdata_i,
    output wire        req_ready_o,
    output wire        req_done_o,
    output wire        req_error_o,
    output wire [63:0] req_rdata_o,
    // External bus pins.
    output wire [23:0] ext_addr_o,
    output wire [31:0] ext_ad_o,
    output wire        ext_ad_oe_o,
    input  wire [31:0] ext_ad_i,
    output wire [7:0]  region_select_n_o,
    output wire        ext_rd_n_o,
    output wire        ext_wr_n_o,
    output wire        read_modify_write_ind_o,
    output wire [2:0]  access_type_sel_o,
    output wire        bus_hold_o,
    output wire        ext_sync_clock_o
);

////////////////////////////////////////////////////////////////////////////////

localparam [2:0] ST_IDLE  = 3'd0;
localparam [2:0] ST_MATCH = 3'd1;
localparam [2:0] ST_PARAM = 3'd2;
localparam [2:0] ST_ADR   = 3'd3;
localparam [2:0] ST_DAT   = 3'd4;

reg  [31:0] addsel_reg [0:7];
reg  [31:0] buscon_reg [0:7];
reg  [31:0] con_reg;
reg         wait_reg;
reg  [31:0] readdata_reg;

reg  [2:0]  state_reg;
reg  [2:0]  region_reg;
reg  [31:0] addr_reg;
reg  [31:0] cur_addr_reg;
reg  [1:0]  size_reg;
reg         src_reg;
reg         write_reg;
reg         rmw_reg;
reg  [63:0] wdata_reg;
reg  [63:0] rdata_reg;
reg  [1:0]  beats_left_reg;
reg         ready_reg;
reg         done_reg;
reg         error_reg;

reg  [23:0] ext_addr_reg;
reg  [31:0] ext_ad_reg;
reg         ext_ad_oe_reg;
reg  [7:0]  select_n_reg;
reg         rd_n_reg;
reg         wr_n_reg;
reg         rmw_ind_reg;
reg  [2:0]  atype_out_reg;
reg         hold_reg;
reg  [1:0]  div_cnt_reg;
reg         sync_clk_reg;

integer     i;
integer     k;

////////////////////////////////////////////////////////////////////////////////
// Register slave: every answer comes one cycle after the request, from a flip-flop.

function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer      b;
    begin
        merge = old_v;
        for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
    end
endfunction

reg  [31:0] rd_mux;
wire [2:0]  reg_idx  = avs_address_i[5:3];
wire        wr_fire  = avs_write_i & ~wait_reg;

always @* begin
    rd_mux = 32'h0000_0000;
    if (!avs_address_i[`OFS_TABLE_BIT]) begin
        rd_mux = avs_address_i[`OFS_BUSCON_BIT] ? buscon_reg[reg_idx] : addsel_reg[reg_idx];
    end else if (avs_address_i == `OFS_CON) begin
        rd_mux = con_reg;
    end else if (avs_address_i == `OFS_STATUS) begin
        rd_mux[`STAT_HOLD] = hold_reg;
        rd_mux[`STAT_REGION_LO +: 3] = region_reg;
        rd_mux[`STAT_STATE_LO +: 3] = state_reg;
    end
end

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        wait_reg     <= 1'b1;
        readdata_reg <= 32'h0000_0000;
        con_reg      <= `CON_RST;
        for (i = 0; i < 8; i = i + 1) begin
            addsel_reg[i] <= `ADDSEL_RST;
            buscon_reg[i] <= `BUSCON_RST;
        end
    end else begin
        wait_reg <= ~((avs_read_i | avs_write_i) & wait_reg);
        if ((avs_read_i | avs_write_i) & wait_reg) readdata_reg <= rd_mux;
        if (wr_fire) begin
            if (!avs_address_i[`OFS_TABLE_BIT] && avs_address_i[`OFS_BUSCON_BIT]) begin
                buscon_reg[reg_idx] <= merge(rd_mux, avs_writedata_i, avs_byteenable_i);
            end else if (!avs_address_i[`OFS_TABLE_BIT]) begin
                addsel_reg[reg_idx] <= merge(rd_mux, avs_writedata_i, avs_byteenable_i);
            end else if (avs_address_i == `OFS_CON) begin
                con_reg <= merge(rd_mux, avs_writedata_i, avs_byteenable_i);
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Region comparison on the captured request address.

wire [7:0] hit;
reg  [2:0] hit_idx;
genvar     g;

generate
    for (g = 0; g < 8; g = g + 1) begin : g_match
        wire [31:0] asel    = addsel_reg[g];
        wire [3:0]  msk     = asel[`ASEL_MASK_LO +: 4];
        wire [14:0] keep    = ~(15'h7fff >> msk);
        wire        seg_ok  = (addr_reg[31:28] == asel[31:28])
                            | (asel[`ASEL_ALTERNATE_SEGMENT_ENABLE] & (addr_reg[31:28] == asel[`ASEL_ALTERNATE_SEGMENT_LO +: 4]));
        wire        low_ok  = (((addr_reg[26:12] ^ asel[26:12]) & keep) == 15'h0000);
        assign hit[g] = asel[`ASEL_EN] & seg_ok & (addr_reg[27] == asel[27]) & low_ok;
    end
endgenerate

always @* begin
    hit_idx = 3'd0;
    for (k = 7; k >= 0; k = k - 1) begin
        if (hit[k]) hit_idx = k[2:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Parameters of the selected region. They are read live from the table, so
// software must not rewrite a region while an access to it is running.

wire [31:0] bc     = buscon_reg[region_reg];
wire [2:0]  atype  = bc[`BC_ATYPE_LO +: 3];
wire [1:0]  pw     = bc[`BC_PW_LO +: 2];
wire        port16 = (pw == `PW_16);
wire        align  = bc[`BC_ALIGN];
wire        is_mux = (atype == `AT_MUX);
wire        big    = bc[`BC_ENDIAN] & port16;

wire        bad    = ((pw != `PW_16) & (pw != `PW_32))
                   | (atype > `AT_SDRAM1)
                   | (write_reg & bc[`BC_WP])
                   | (src_reg & (size_reg == `SZ_64));

reg  [1:0]  last_beat;
always @* begin
    last_beat = 2'd0;
    if (port16 && size_reg == `SZ_64) last_beat = 2'd3;
    else if (size_reg == `SZ_64 || (port16 && size_reg == `SZ_32)) last_beat = 2'd1;
end

wire [31:0] step      = port16 ? 32'h0000_0002 : 32'h0000_0004;
wire [31:0] nxt_addr  = cur_addr_reg + step;
wire [31:0] beat_addr = (state_reg == ST_PARAM) ? addr_reg :
                        (state_reg == ST_DAT) ? nxt_addr : cur_addr_reg;

wire [1:0]  flip      = (size_reg == `SZ_8) ? 2'b11 : 2'b10;
wire [1:0]  low       = big ? (beat_addr[1:0] ^ flip) : beat_addr[1:0];
wire [31:0] xaddr     = {beat_addr[31:2], low};

wire [23:0] pin_addr  = !align ? xaddr[23:0] :
                        port16 ? xaddr[24:1] : xaddr[25:2];
wire [31:0] mux_addr  = !align ? xaddr :
                        port16 ? {1'b0, xaddr[31:1]} : {2'b00, xaddr[31:2]};

wire        hi_half   = ~src_reg & beat_addr[2];
wire [31:0] wword     = hi_half ? wdata_reg[63:32] : wdata_reg[31:0];
wire [31:0] wbeat     = port16 ? {16'h0000, beat_addr[1] ? wword[31:16] : wword[15:0]}
                               : wword;

wire        cap_hi    = ~src_reg & cur_addr_reg[2];
wire [1:0]  cap_hw    = {cap_hi, cur_addr_reg[1]};

////////////////////////////////////////////////////////////////////////////////
// Prescaler: a one-cycle tick at the divided rate paces the DRAM types.

wire [1:0]  div_sel   = con_reg[`CON_DIV_LO +: 2];
wire [1:0]  div_lim   = (div_sel == `DIV_1) ? 2'd0 : (div_sel == `DIV_2) ? 2'd1 : 2'd3;
wire        tick      = ((div_cnt_reg & div_lim) == 2'd0);
wire        adv       = (atype < `AT_SDRAM0) | tick;

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        div_cnt_reg  <= 2'd0;
        sync_clk_reg <= 1'b0;
    end else begin
        div_cnt_reg  <= div_cnt_reg + 2'd1;
        sync_clk_reg <= tick;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Access sequencer: take, match, select, then address and data phase per beat.

always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
        state_reg      <= ST_IDLE;
        region_reg     <= 3'd0;
        addr_reg       <= 32'h0000_0000;
        cur_addr_reg   <= 32'h0000_0000;
        size_reg       <= `SZ_8;
        src_reg        <= 1'b0;
        write_reg      <= 1'b0;
        rmw_reg        <= 1'b0;
        wdata_reg      <= 64'h0000_0000_0000_0000;
        rdata_reg      <= 64'h0000_0000_0000_0000;
        beats_left_reg <= 2'd0;
        ready_reg      <= 1'b1;
        done_reg       <= 1'b0;
        error_reg      <= 1'b0;
        ext_addr_reg   <= 24'h00_0000;
        ext_ad_reg     <= 32'h0000_0000;
        ext_ad_oe_reg  <= 1'b0;
        select_n_reg   <= 8'hff;
        rd_n_reg       <= 1'b1;
        wr_n_reg       <= 1'b1;
        rmw_ind_reg    <= 1'b1;
        atype_out_reg  <= `AT_DEMUX;
        hold_reg       <= 1'b0;
    end else begin
        done_reg  <= 1'b0;
        error_reg <= 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid_i) begin
                    addr_reg  <= req_addr_i;
                    size_reg  <= req_size_i;
                    src_reg   <= req_src_i;
                    write_reg <= req_write_i;
                    rmw_reg   <= req_rmw_i;
                    wdata_reg <= req_wdata_i;
                    rdata_reg <= 64'h0000_0000_0000_0000;
                    ready_reg <= 1'b0;
                    state_reg <= ST_MATCH;
                end
            end
            ST_MATCH: begin
                if (hit == 8'h00) begin
                    done_reg  <= 1'b1;
                    error_reg <= 1'b1;
                    ready_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end else begin
                    region_reg <= hit_idx;
                    state_reg  <= ST_PARAM;
                end
            end
            ST_PARAM: begin
                if (bad) begin
                    done_reg  <= 1'b1;
                    error_reg <= 1'b1;
                    ready_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end else begin
                    select_n_reg   <= ~(8'h01 << region_reg);
                    ext_addr_reg   <= pin_addr;
                    ext_ad_reg     <= is_mux ? mux_addr : wbeat;
                    ext_ad_oe_reg  <= is_mux | write_reg;
                    rmw_ind_reg    <= ~(rmw_reg & ~write_reg);
                    atype_out_reg  <= atype;
                    hold_reg       <= 1'b1;
                    cur_addr_reg   <= beat_addr;
                    beats_left_reg <= last_beat;
                    state_reg      <= ST_ADR;
                end
            end
            ST_ADR: begin
                if (adv) begin
                    rd_n_reg      <= write_reg;
                    wr_n_reg      <= ~write_reg;
                    ext_ad_reg    <= wbeat;
                    ext_ad_oe_reg <= write_reg;
                    state_reg     <= ST_DAT;
                end
            end
            ST_DAT: begin
                if (adv) begin
                    if (!write_reg && port16) rdata_reg[cap_hw*16 +: 16] <= ext_ad_i[15:0];
                    else if (!write_reg) rdata_reg[cap_hi*32 +: 32] <= ext_ad_i;
                    rd_n_reg <= 1'b1;
                    wr_n_reg <= 1'b1;
                    if (beats_left_reg == 2'd0) begin
                        select_n_reg  <= 8'hff;
                        rmw_ind_reg   <= 1'b1;
                        hold_reg      <= 1'b0;
                        ext_ad_oe_reg <= 1'b0;
                        done_reg      <= 1'b1;
                        ready_reg     <= 1'b1;
                        state_reg     <= ST_IDLE;
                    end else begin
                        beats_left_reg <= beats_left_reg - 2'd1;
                        cur_addr_reg   <= beat_addr;
                        ext_addr_reg   <= pin_addr;
                        ext_ad_reg     <= is_mux ? mux_addr : wbeat;
                        ext_ad_oe_reg  <= is_mux | write_reg;
                        state_reg      <= ST_ADR;
                    end
                end
            end
            default: state_reg <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////

assign avs_readdata_o          = readdata_reg;
assign avs_waitrequest_o       = wait_reg;
assign req_ready_o             = ready_reg;
assign req_done_o              = done_reg;
assign req_error_o             = error_reg;
assign req_rdata_o             = rdata_reg;
assign ext_addr_o              = ext_addr_reg;
assign ext_ad_o                = ext_ad_reg;
assign ext_ad_oe_o             = ext_ad_oe_reg;
assign region_select_n_o       = select_n_reg;
assign ext_rd_n_o              = rd_n_reg;
assign ext_wr_n_o              = wr_n_reg;
assign read_modify_write_ind_o = rmw_ind_reg;
assign access_type_sel_o       = atype_out_reg;
assign bus_hold_o              = hold_reg;
assign ext_sync_clock_o        = sync_clk_reg;

endmodule

// ### sim/ext_bus_region_chk.sv
// Port timing checker of the external bus region block.
`timescale 1ns/1ps
module ext_bus_region_chk (
    // Clock and reset.
    input wire       clk_sys_i,
    input wire       nrst_i,
    // Register bus.
    input wire       avs_read_i,
    input wire       avs_write_i,
    input wire       avs_waitrequest_o,
    // Request port.
    input wire       req_valid_i,
    input wire       req_ready_o,
    input wire       req_done_o,
    input wire       req_error_o,
    // External pins.
    input wire [7:0] region_select_n_o,
    input wire       ext_rd_n_o,
    input wire       ext_wr_n_o,
    input wire       ext_ad_oe_o,
    input wire       read_modify_write_ind_o,
    input wire [2:0] access_type_sel_o,
    input wire       bus_hold_o
);
    wire act = region_select_n_o != 8'hFF;
    reg  sel_seen;
    // Selects since the take, so a late error is caught.
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) sel_seen <= 1'b0;
        else if (req_valid_i && req_ready_o) sel_seen <= 1'b0;
        else if (act) sel_seen <= 1'b1;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence s_take;
        req_valid_i && req_ready_o;
    endsequence
    sequence s_idle;
        !act && !req_done_o;
    endsequence
    start_window_a: assert property (s_take |=> s_idle ##1 ((req_done_o && req_error_o)
        or (s_idle ##1 (act || (req_done_o && req_error_o)))))
        else $error("late start");
    err_no_bus_a: assert property (req_error_o |-> !sel_seen && !act && req_done_o)
        else $error("error after select");
    one_select_a: assert property ($onehot0(~region_select_n_o))
        else $error("two selects");
    hold_owned_a: assert property (act |-> bus_hold_o)
        else $error("select without hold");
    hold_end_a: assert property ($fell(bus_hold_o) |-> req_done_o)
        else $error("early hold release");
    rmw_read_a: assert property (!read_modify_write_ind_o |-> act && ext_wr_n_o)
        else $error("stray modify");
    type_range_a: assert property (act |-> access_type_sel_o <= 3'h4)
        else $error("bad type");
    strobe_sel_a: assert property (!(ext_rd_n_o && ext_wr_n_o) |-> act && (ext_rd_n_o || ext_wr_n_o))
        else $error("stray strobe");
    oe_dir_a: assert property (ext_ad_oe_o |-> act && ext_rd_n_o)
        else $error("stray drive");
    ready_drop_a: assert property (s_take |=> !req_ready_o)
        else $error("ready kept");
    wait_pulse_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("answer timing");
endmodule
bind ext_bus_region ext_bus_region_chk chk (.clk_sys_i, .nrst_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .req_valid_i, .req_ready_o, .req_done_o, .req_error_o,
    .region_select_n_o, .ext_rd_n_o, .ext_wr_n_o, .ext_ad_oe_o, .read_modify_write_ind_o,
    .access_type_sel_o, .bus_hold_o);

// ### sim/ext_mem_model.sv
// Behavioural external memory that answers reads and logs each beat.
`timescale 1ns/1ps
module ext_mem_model (
    // Clock.
    input  wire        clk_sys_i,
    // Bus from the block.
    input  wire [23:0] ext_addr_o,
    input  wire [31:0] ext_ad_o,
    input  wire [7:0]  region_select_n_o,
    input  wire        ext_rd_n_o,
    input  wire        ext_wr_n_o,
    input  wire        read_modify_write_ind_o,
    input  wire [2:0]  access_type_sel_o,
    // Data back to the block.
    output wire [31:0] ext_ad_i
);
    logic [31:0] last = 32'h0000_0000;
    logic        aarm = 1'b1;
    logic        wlow = 1'b0;
    logic        rmw_seen = 1'b0;
    logic [66:0] beats[$];
    logic [31:0] wdat[$];
    wire         act = region_select_n_o != 8'hFF;
    // Released lines show the inverse of the last value, so a stale sample is caught.
    assign ext_ad_i = (act && !ext_rd_n_o) ? {8'h5A, ext_addr_o} : ~last;
    ////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        last <= ext_ad_i;
        if (act && ext_rd_n_o && ext_wr_n_o && aarm)
            beats.push_back({region_select_n_o, access_type_sel_o, ext_ad_o, ext_addr_o});
        if (act && !ext_wr_n_o && !wlow) wdat.push_back(ext_ad_o);
        if (act && !read_modify_write_ind_o) rmw_seen <= 1'b1;
        aarm <= !act || !ext_rd_n_o || !ext_wr_n_o;
        wlow <= act && !ext_wr_n_o;
    end
endmodule

// ### sim/ext_bus_region_tb_top.sv
// Self-checking bench of the external bus region block.
`timescale 1ns/1ps
module ext_bus_region_tb_top;
    logic        clk_sys_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0, w, read_modify_write_ind = 0;
    logic        req_valid_i = 0, req_src_i = 0, req_write_i = 0, req_rmw_i = 0;
    logic [6:0]  avs_address_i = 7'h00;
    logic [31:0] avs_writedata_i = 0, req_addr_i = 0, q, a;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [1:0]  req_size_i = 2'h0, sz;
    logic [63:0] req_wdata_i = 0, wd = 0, r;
    wire  [31:0] avs_readdata_o, ext_ad_o, ext_ad_i;
    wire  [63:0] req_rdata_o;
    wire  [23:0] ext_addr_o;
    wire  [7:0]  region_select_n_o;
    wire  [2:0]  access_type_sel_o;
    wire         avs_waitrequest_o, req_ready_o, req_done_o, req_error_o, ext_ad_oe_o;
    wire         ext_rd_n_o, ext_wr_n_o, read_modify_write_ind_o, bus_hold_o, ext_sync_clock_o;
    int          error_cnt = 0, checks_done = 0, rg, cnt;
    logic [31:0] cfg [16] = '{32'h8000_00F1, 32'h0000_0020, 32'h8000_0001, 32'h0000_0020,
        32'hA000_0001, 32'h0000_0010, 32'hD000_0001, 32'h0000_0050, 32'hE000_0001,
        32'h0000_00A0, 32'h9000_00F0, 32'h0000_0020, 32'hB000_0001, 32'h0000_0000,
        32'hF000_0001, 32'h0000_00A0};
    ext_bus_region uut (.clk_sys_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .req_valid_i,
        .req_src_i, .req_addr_i, .req_size_i, .req_write_i, .req_rmw_i, .req_wdata_i,
        .req_ready_o, .req_done_o, .req_error_o, .req_rdata_o, .ext_addr_o, .ext_ad_o,
        .ext_ad_oe_o, .ext_ad_i, .region_select_n_o, .ext_rd_n_o, .ext_wr_n_o,
        .read_modify_write_ind_o, .access_type_sel_o, .bus_hold_o, .ext_sync_clock_o);
    ext_mem_model mdl (.clk_sys_i, .ext_addr_o, .ext_ad_o, .region_select_n_o, .ext_rd_n_o,
        .ext_wr_n_o, .read_modify_write_ind_o, .access_type_sel_o, .ext_ad_i);
    initial forever #50 clk_sys_i = ~clk_sys_i;
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        error_cnt++;
        tally_and_finish;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Read at the edge, before its updates land.
    task automatic reg_io(input logic wr, input logic [6:0] ad, input logic [31:0] d);
        avs_address_i <= ad;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic acc(logic s, logic [31:0] ra, logic [1:0] rs, logic rw, logic ee,
                       int g = 0, int x = 0, int sh = 0, int t = 0);
        int c, st, n;
        logic [66:0] b;
        st = (g == 2 || g == 3) ? 2 : 4;
        n = ee ? 0 : ((1 << rs) > st ? (1 << rs) / st : 1);
        mdl.beats.delete();
        mdl.wdat.delete();
        mdl.rmw_seen = 1'b0;
        req_src_i <= s;
        req_addr_i <= ra;
        req_size_i <= rs;
        req_write_i <= rw;
        req_rmw_i <= read_modify_write_ind;
        req_wdata_i <= wd;
        req_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        c = 0;
        do begin @(posedge clk_sys_i); c++; end while (req_done_o !== 1'b1 && c < 300);
        if (c >= 300) error_cnt++;
        r = req_rdata_o;
        chk(req_error_o, ee);
        chk(mdl.beats.size(), n);
        for (int k = 0; k < n && k < mdl.beats.size(); k++) begin
            b = mdl.beats[k];
            chk(b[23:0], 24'(((ra + k * st) ^ x) >> sh));
            chk(b[66:59] ^ (8'h01 << g), 8'hFF);
            chk(b[58:56], t);
        end
    endtask
    function automatic logic [63:0] exp_rd(logic [31:0] ea, logic [1:0] es, bit p16);
        logic [63:0] v = 0;
        logic [31:0] b;
        int st = p16 ? 2 : 4;
        for (int k = 0; k < (1 << es) / st; k++) begin
            b = ea + k * st;
            v |= (p16 ? 64'(b[15:0]) : 64'({8'h5A, b[23:0]})) << (b[2:0] * 8);
        end
        return v;
    endfunction
    function automatic logic [31:0] exp_wr(logic [31:0] ea, bit p16);
        logic [63:0] v = wd >> (ea[2:0] * 8);
        return p16 ? {16'h0000, v[15:0]} : v[31:0];
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(66172));
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        chk({region_select_n_o, read_modify_write_ind_o}, 9'h1FF);
        for (int i = 0; i < 16; i++) begin
            reg_io(0, 7'(4 * i), 0);
            chk(q, i % 2 ? 32'h0000_0020 : 32'h0000_0000);
        end
        reg_io(1, 7'h48, 32'hFFFF_FFFF);
        reg_io(0, 7'h48, 0);
        chk(q, 32'h0000_0000);
        acc(0, 32'h8000_0000, 2, 0, 1);
        for (int i = 0; i < 16; i++) begin
            reg_io(1, 7'(4 * i), cfg[i]);
            reg_io(0, 7'(4 * i), 0);
            chk(q, cfg[i]);
        end
        $display("end registers");
        acc(0, 32'h8000_0FF8, 3, 0, 0);
        acc(0, 32'h8000_1000, 2, 0, 0, 1);
        acc(0, 32'h8800_0000, 2, 0, 1);
        acc(0, 32'h9000_0000, 2, 0, 1);
        acc(0, 32'hB000_0000, 2, 0, 1);
        acc(1, 32'hA000_0010, 2, 0, 0, 2);
        acc(0, 32'hA000_0003, 0, 0, 0, 2);
        for (int k = 0; k < 4; k++) begin
            acc(0, 32'hD000_0000 + k, 0, 0, 0, 3, 3);
            if (k % 2 == 0) acc(0, 32'hD000_0000 + k, 1, 0, 0, 3, 2);
        end
        acc(1, 32'hD000_0004, 2, 0, 0, 3, 2);
        acc(0, 32'hD000_0008, 3, 0, 0, 3, 2);
        reg_io(1, 7'h04, 32'h0000_0060);
        acc(0, 32'h8000_0001, 0, 0, 0);
        $display("end matching and byte order");
        for (int t = 0; t < 5; t++) begin
            reg_io(1, 7'h0C, 32'h0000_0020 | t);
            acc(0, 32'h8000_2000, 2, 0, 0, 1, 0, 0, t);
        end
        reg_io(1, 7'h0C, 32'h0000_0025);
        acc(0, 32'h8000_2000, 2, 0, 1);
        reg_io(1, 7'h0C, 32'h0000_0121);
        acc(0, 32'h8000_2004, 2, 0, 0, 1, 0, 2, 1);
        chk(mdl.beats[0][55:24], 32'h2000_0801);
        reg_io(1, 7'h0C, 32'h0000_0020);
        reg_io(1, 7'h14, 32'h0000_0110);
        acc(0, 32'hA000_0104, 2, 0, 0, 2, 0, 1);
        reg_io(1, 7'h14, 32'h0000_0010);
        wd = 64'h1122_3344_5566_7788;
        acc(0, 32'h8000_2004, 2, 1, 0, 1);
        chk(mdl.wdat[0], 32'h1122_3344);
        acc(0, 32'hA000_0006, 1, 1, 0, 2);
        chk(mdl.wdat[0][15:0], 16'h1122);
        wd = 64'h0000_0000_BEEF_0000;
        acc(1, 32'hA000_0012, 1, 1, 0, 2);
        chk(mdl.wdat[0][15:0], 16'hBEEF);
        acc(0, 32'hE000_0000, 2, 1, 1);
        acc(0, 32'hF000_0000, 2, 1, 1);
        acc(0, 32'hE000_0000, 2, 0, 0, 4);
        read_modify_write_ind = 1'b1;
        acc(1, 32'h8000_2000, 2, 0, 0, 1);
        chk(mdl.rmw_seen, 1'b1);
        read_modify_write_ind = 1'b0;
        $display("end types alignment writes");
        for (int d = 0; d < 4; d++) begin
            reg_io(1, 7'h40, d);
            cnt = 0;
            repeat (16) begin @(posedge clk_sys_i); cnt += ext_sync_clock_o; end
            chk(cnt, 16 >> (d > 2 ? 2 : d));
        end
        $display("end clock divider");
        for (int k = 0; k < 24; k++) begin
            rg = $urandom_range(2, 1);
            sz = $urandom_range(3, 2);
            w = $urandom_range(1, 0);
            wd = {$urandom, $urandom};
            a = (rg == 1 ? 32'h8100_0000 : 32'hA000_0000) | ($urandom & 32'h00FF_FFF8);
            if (sz == 2) a |= $urandom & 4;
            acc(0, a, sz, w, 0, rg);
            if (w) chk(mdl.wdat[0], exp_wr(a, rg == 2));
            else chk(r, exp_rd(a, sz, rg == 2));
        end
        $display("end random traffic");
        tally_and_finish;
    end
endmodule
